// File: include/ccsr_consts.svh
`ifndef CCSR_CONSTS_SVH
`define CCSR_CONSTS_SVH

// Control register selects used by the load/store control instructions.
`define CCSR_SEL_EPSR      2'h0
`define CCSR_SEL_WATCH     2'h1
`define CCSR_SEL_DIRBASE   2'h2

// Extended status field positions.
`define CCSR_EP_IL         0
`define CCSR_EP_PEF        1
`define CCSR_EP_BEF        2
`define CCSR_EP_INT        3
`define CCSR_EP_DCS_LO     4
`define CCSR_EP_DCS_HI     7
`define CCSR_EP_PBM        8
`define CCSR_EP_BE         9
`define CCSR_EP_OF         10
`define CCSR_EP_BS         11
`define CCSR_EP_DI         12
`define CCSR_EP_TAI        13
`define CCSR_EP_PT         14
`define CCSR_EP_PI         15
`define CCSR_EP_SO         16

// Directory base field positions.
`define CCSR_DB_ATE        0
`define CCSR_DB_DPS_LO     1
`define CCSR_DB_DPS_HI     3
`define CCSR_DB_BL         4
`define CCSR_DB_ITI        5
`define CCSR_DB_LB         6
`define CCSR_DB_DTB_LO     12

// Reset values of the error flags.
`define CCSR_RST_PEF       1'b1
`define CCSR_RST_BEF       1'b1

// Data cache size code and the base of the page compare.
`define CCSR_DCS_VALUE     4'h2
`define CCSR_PAGE_BASE     5'd12

`endif

// File: include/ccsr_pkg.sv
package ccsr_pkg;

	// Arithmetic operations that update the overflow flag.
	typedef enum logic [1:0] {
		CCSR_ADDS = 2'h0,
		CCSR_ADDU = 2'h1,
		CCSR_SUBS = 2'h2,
		CCSR_SUBU = 2'h3
	} ccsr_alu_t;

	// Bus lock sequencer, one-hot.
	typedef enum logic [3:0] {
		CCSR_LK_IDLE  = 4'h1,
		CCSR_LK_ARMED = 4'h2,
		CCSR_LK_HELD  = 4'h4,
		CCSR_LK_DRAIN = 4'h8
	} ccsr_lock_t;

	typedef struct packed {
		logic        strapDone;
		logic        strongOrder;
		logic        lateBo1;
		logic        lockIntr;
		logic        parityFault;
		logic        busFault;
		logic        intFlag;
		logic        pteSel;
		logic        byteSwap;
		logic        overflow;
		logic        supFault;
		logic        delaySlot;
		logic        autoInc;
		logic        fpTrapEn;
		logic        fpUsed;
		logic [31:0] watchAddr;
		logic [19:0] tableBase;
		logic        transEn;
		logic [2:0]  dramPage;
		logic        lateBo2;
		ccsr_lock_t  lockSt;
		logic        lockOut;
		logic [31:0] prevBusAddr;
		logic        samePage;
		logic        pteBit;
		logic [31:0] memAddrOut;
		logic        watchTrap;
		logic        cacheFlush;
		logic        errTrap;
		logic        fpTrap;
		logic        instrTrapSet;
		logic [31:0] rdData;
	} ccsr_state_t;

endpackage : ccsr_pkg

// File: logic/ccsr_sync.sv
`timescale 1ns/1ps

// Two-stage synchroniser; the first stage feeds only the second.
module ccsr_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         ce,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	logic [W-1:0] meta_r;

	// Both stages hold while the clock enable is low.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			dout   <= '0;
		end else if (ce) begin
			meta_r <= din;
			dout   <= meta_r;
		end
	end

endmodule : ccsr_sync

// File: logic/ccsr_regs.sv
// Summary of operation
// - Parity trap sets flag; masks errors; reset set.
// - Bus fault pin sets flag; masks errors; reset set.
// - Interrupt flag mirrors pin, zero when locked.
// - Read-only data cache size code.
// - Page-table bit output picks cache-disable or write-through.
// - Byte swap complements low address bits, aligns.
// - Overflow from carries per add/subtract kind.
// - Overflow writable by software only in supervisor.
// - Unmasked error in supervisor mode sets supervisor fault.
// - Trap after delayed branch sets slot flag.
// - Trap on autoincrement instruction sets flag.
// - Pipe trap enable traps pipe instructions early.
// - Pipe-used flag set on decode when trapping, else on execute.
// - Strong ordering from write-buffer pin at reset.
// - Watch compare ignores low bits by size.
// - Watch match traps before the access completes.
// - Translation enabled only while enable bit set.
// - Same-page output compares high bus address bits.
// - Bus lock output follows lock bit, drops late.
// - Trap in locked sequence clears lock, flags it.
// - Flush bit invalidates caches, reads as zero.
// - Late back-off extension sticky, blocked by strap.
`timescale 1ns/1ps
`include "ccsr_consts.svh"

module ccsr_regs
	import ccsr_pkg::*;
#(
	parameter logic [3:0] DCACHE_SIZE = `CCSR_DCS_VALUE
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic        ctlWrEn,
	input  wire logic        ctlRdEn,
	input  wire logic [1:0]  ctlSel,
	input  wire logic [31:0] ctlWrData,
	input  wire logic        supervisorMode,
	input  wire logic        busFaultPin,
	input  wire logic        irqPin,
	input  wire logic        wrBufEmptyPin_n,
	input  wire logic        lateBackoffStrap,
	input  wire logic        parityErr,
	input  wire logic        trapValid,
	input  wire logic        trapDelaySlot,
	input  wire logic        trapAutoInc,
	input  wire logic        pteCacheDisable,
	input  wire logic        pteWriteThrough,
	input  wire logic        memValid,
	input  wire logic [31:0] memAddr,
	input  wire logic [1:0]  memSize,
	input  wire logic        aluValid,
	input  wire logic [1:0]  aluOp,
	input  wire logic        carry31,
	input  wire logic        carry30,
	input  wire logic        fpDecode,
	input  wire logic        fpPipeExec,
	input  wire logic        opValid,
	input  wire logic        opRead,
	input  wire logic        opWrite,
	input  wire logic [31:0] opAddr,
	input  wire logic [1:0]  opSize,
	input  wire logic        readWatchEnable,
	input  wire logic        writeWatchEnable,
	input  wire logic        busCycleValid,
	input  wire logic [31:0] busAddr,
	input  wire logic        busReq,
	input  wire logic        busReqFetchWb,
	input  wire logic        loadStore,
	input  wire logic        lockInstr,
	input  wire logic        unlockInstr,
	output logic [31:0]      ctlRdData,
	output logic             pteBitOutput,
	output logic [31:0]      memAddrOut,
	output logic             watchTrap,
	output logic             errTrap,
	output logic             fpTrap,
	output logic             instrTrapSet,
	output logic             translationEnable,
	output logic             samePage,
	output logic             busLockOut,
	output logic             cacheFlush,
	output logic             lateBackoff2,
	output logic             strongOrder
);

	////////////////////////////////////////////////////////////////////////////////
	// Reset release and pin synchronisers.

	logic       rstInt_n;
	logic [3:0] pinSync;
	logic       busFaultS;
	logic       irqS;
	logic       wrBufEmptyS_n;
	logic       strapLateS;

	ccsr_sync #(.W(1)) u_rstSync (
		.clk   (clk),
		.rst_n (rst_n),
		.ce    (1'b1),
		.din   (1'b1),
		.dout  (rstInt_n)
	);

	// Pin synchroniser resets low, so the write-buffer pin reads active until
	// it has passed both stages; the strap capture below waits for that.
	ccsr_sync #(.W(4)) u_pinSync (
		.clk   (clk),
		.rst_n (rstInt_n),
		.ce    (ce),
		.din   ({lateBackoffStrap, wrBufEmptyPin_n, irqPin, busFaultPin}),
		.dout  (pinSync)
	);

	assign busFaultS     = pinSync[0];
	assign irqS          = pinSync[1];
	assign wrBufEmptyS_n = pinSync[2];
	assign strapLateS    = pinSync[3];

	////////////////////////////////////////////////////////////////////////////////
	// State.

	ccsr_state_t st_r;
	ccsr_state_t st_nxt;
	logic [1:0]  strapWait_r;
	logic        errMasked;
	logic        lockSeq;
	logic        wrSup;
	logic [31:0] swapAddr;
	logic [31:0] watchMask;
	logic        watchHit;
	logic [31:0] pageMask;
	logic [31:0] epsrView;
	logic [31:0] dirView;

	// Errors stay masked while either error flag is up.
	assign errMasked = st_r.parityFault | st_r.busFault;
	assign lockSeq   = (st_r.lockSt != CCSR_LK_IDLE);
	assign wrSup     = ctlWrEn & supervisorMode;

	// Byte swap complements the low three bits, then aligns to operand size.
	always_comb begin
		swapAddr = {memAddr[31:3], ~memAddr[2:0]};
		unique case (memSize)
			2'h0: swapAddr = swapAddr;
			2'h1: swapAddr[0] = 1'b0;
			2'h2: swapAddr[1:0] = 2'h0;
			2'h3: swapAddr[2:0] = 3'h0;
		endcase
	end

	// Overlapping accesses hit: the low bits covered by the operand are ignored.
	always_comb begin
		watchMask = 32'hffffffff;
		unique case (opSize)
			2'h0: watchMask = 32'hffffffff;
			2'h1: watchMask = 32'hfffffffe;
			2'h2: watchMask = 32'hfffffffc;
			2'h3: watchMask = 32'hfffffff8;
		endcase
	end
	assign watchHit = ((opAddr & watchMask) == (st_r.watchAddr & watchMask));

	// Page compare ignores the low 12 plus page-size bits.
	assign pageMask = 32'hffffffff << (`CCSR_PAGE_BASE + {2'h0, st_r.dramPage});

	assign epsrView = {15'h0, st_r.strongOrder, st_r.fpUsed, st_r.fpTrapEn, st_r.autoInc,
		st_r.delaySlot, st_r.supFault, st_r.overflow, st_r.byteSwap, st_r.pteSel,
		DCACHE_SIZE, st_r.intFlag, st_r.busFault, st_r.parityFault, st_r.lockIntr};
	// Flush bit is never stored and reads as zero; lock bit mirrors the sequencer.
	assign dirView = {st_r.tableBase, 5'h0, st_r.lateBo2, 1'b0,
		(st_r.lockSt == CCSR_LK_ARMED) | (st_r.lockSt == CCSR_LK_HELD),
		st_r.dramPage, st_r.transEn};

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic. Software writes land first so that hardware sets win.

	always_comb begin
		st_nxt = st_r;
		st_nxt.watchTrap    = 1'b0;
		st_nxt.cacheFlush   = 1'b0;
		st_nxt.errTrap      = 1'b0;
		st_nxt.fpTrap       = 1'b0;
		st_nxt.instrTrapSet = 1'b0;

		// Strap capture after both synchroniser stages hold real pin levels.
		if (!st_r.strapDone && strapWait_r == 2'h3) begin
			st_nxt.strapDone   = 1'b1;
			st_nxt.strongOrder = ~wrBufEmptyS_n;
			st_nxt.lateBo1     = strapLateS;
		end

		// Software writes through the control store instruction.
		if (wrSup && ctlSel == `CCSR_SEL_EPSR) begin
			st_nxt.lockIntr    = ctlWrData[`CCSR_EP_IL];
			st_nxt.parityFault = ctlWrData[`CCSR_EP_PEF];
			st_nxt.busFault    = ctlWrData[`CCSR_EP_BEF];
			st_nxt.pteSel      = ctlWrData[`CCSR_EP_PBM];
			st_nxt.byteSwap    = ctlWrData[`CCSR_EP_BE];
			st_nxt.overflow    = ctlWrData[`CCSR_EP_OF];
			st_nxt.supFault    = ctlWrData[`CCSR_EP_BS];
			st_nxt.delaySlot   = ctlWrData[`CCSR_EP_DI];
			st_nxt.autoInc     = ctlWrData[`CCSR_EP_TAI];
			st_nxt.fpTrapEn    = ctlWrData[`CCSR_EP_PT];
			st_nxt.fpUsed      = ctlWrData[`CCSR_EP_PI];
		end
		if (wrSup && ctlSel == `CCSR_SEL_WATCH) begin
			st_nxt.watchAddr = ctlWrData;
		end
		// Writing the lock bit has no defined effect, so it is ignored here.
		if (wrSup && ctlSel == `CCSR_SEL_DIRBASE) begin
			st_nxt.tableBase  = ctlWrData[31:`CCSR_DB_DTB_LO];
			st_nxt.transEn    = ctlWrData[`CCSR_DB_ATE];
			st_nxt.dramPage   = ctlWrData[`CCSR_DB_DPS_HI:`CCSR_DB_DPS_LO];
			st_nxt.cacheFlush = ctlWrData[`CCSR_DB_ITI];
			if (ctlWrData[`CCSR_DB_LB] && !st_r.lateBo1) begin
				st_nxt.lateBo2 = 1'b1;
			end
		end

		// Bus and parity errors; the trap is taken only while unmasked.
		if (busFaultS) begin
			st_nxt.busFault = 1'b1;
		end
		if (parityErr && !errMasked) begin
			st_nxt.parityFault = 1'b1;
		end
		if ((parityErr || busFaultS) && !errMasked) begin
			st_nxt.errTrap = 1'b1;
			if (supervisorMode) begin
				st_nxt.supFault = 1'b1;
			end
		end

		// The mirror of the interrupt pin is forced low inside a locked sequence.
		st_nxt.intFlag = irqS & ~lockSeq;

		// Trap classification flags.
		if (trapValid && trapDelaySlot) begin
			st_nxt.delaySlot = 1'b1;
		end
		if (trapValid && trapAutoInc) begin
			st_nxt.autoInc = 1'b1;
		end

		// Arithmetic result beats a same-cycle software write.
		if (aluValid) begin
			unique case (ccsr_alu_t'(aluOp))
				CCSR_ADDS, CCSR_SUBS: st_nxt.overflow = carry31 ^ carry30;
				CCSR_ADDU: st_nxt.overflow = carry31;
				CCSR_SUBU: st_nxt.overflow = ~carry31;
			endcase
		end

		// Pipe use: trap at decode when enabled, otherwise note execution.
		if (st_r.fpTrapEn && fpDecode) begin
			st_nxt.fpTrap       = 1'b1;
			st_nxt.instrTrapSet = 1'b1;
			st_nxt.fpUsed       = 1'b1;
		end
		if (!st_r.fpTrapEn && fpPipeExec) begin
			st_nxt.fpUsed = 1'b1;
		end

		// Page-table bit output and byte-order address path.
		st_nxt.pteBit = st_r.pteSel ? pteWriteThrough : pteCacheDisable;
		if (memValid) begin
			st_nxt.memAddrOut = st_r.byteSwap ? swapAddr : memAddr;
		end

		// Watch trap before the load or store commits.
		if (opValid && watchHit &&
				((opRead && readWatchEnable) || (opWrite && writeWatchEnable))) begin
			st_nxt.watchTrap = 1'b1;
		end

		// Same-page compare against the previous bus cycle.
		if (busCycleValid) begin
			st_nxt.samePage    = ((busAddr & pageMask) == (st_r.prevBusAddr & pageMask));
			st_nxt.prevBusAddr = busAddr;
		end

		// Bus lock sequencer.
		unique case (st_r.lockSt)
			CCSR_LK_IDLE: begin
				if (lockInstr) begin
					st_nxt.lockSt = CCSR_LK_ARMED;
				end
			end
			CCSR_LK_ARMED: begin
				if (unlockInstr) begin
					st_nxt.lockSt = CCSR_LK_IDLE;
				end else if (busReq && !busReqFetchWb) begin
					st_nxt.lockSt  = CCSR_LK_HELD;
					st_nxt.lockOut = 1'b1;
				end
			end
			CCSR_LK_HELD: begin
				if (unlockInstr) begin
					st_nxt.lockSt = CCSR_LK_DRAIN;
				end
			end
			CCSR_LK_DRAIN: begin
				if (lockInstr) begin
					st_nxt.lockSt = CCSR_LK_HELD;
				end else if (loadStore) begin
					st_nxt.lockSt  = CCSR_LK_IDLE;
					st_nxt.lockOut = 1'b0;
				end
			end
		endcase

		// A trap inside the sequence drops the lock bit at once. An output not yet raised
		// stays down, so a lock request in the same cycle cannot leave it stuck high.
		if (trapValid && lockSeq) begin
			st_nxt.lockIntr = 1'b1;
			st_nxt.lockOut  = st_r.lockOut;
			st_nxt.lockSt   = st_r.lockOut ? CCSR_LK_DRAIN : CCSR_LK_IDLE;
		end

		// Read data is registered one cycle after the read strobe.
		if (ctlRdEn) begin
			unique case (ctlSel)
				`CCSR_SEL_EPSR:    st_nxt.rdData = epsrView;
				`CCSR_SEL_WATCH:   st_nxt.rdData = st_r.watchAddr;
				`CCSR_SEL_DIRBASE: st_nxt.rdData = dirView;
				default:           st_nxt.rdData = 32'h00000000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register; reset loads constants only.

	always_ff @(posedge clk or negedge rstInt_n) begin
		if (!rstInt_n) begin
			st_r             <= '0;
			st_r.parityFault <= `CCSR_RST_PEF;
			st_r.busFault    <= `CCSR_RST_BEF;
			st_r.lockSt      <= CCSR_LK_IDLE;
			strapWait_r      <= 2'h0;
		end else if (ce) begin
			st_r <= st_nxt;
			if (strapWait_r != 2'h3) begin
				strapWait_r <= strapWait_r + 2'h1;
			end
		end
	end

	assign ctlRdData         = st_r.rdData;
	assign pteBitOutput      = st_r.pteBit;
	assign memAddrOut        = st_r.memAddrOut;
	assign watchTrap         = st_r.watchTrap;
	assign errTrap           = st_r.errTrap;
	assign fpTrap            = st_r.fpTrap;
	assign instrTrapSet      = st_r.instrTrapSet;
	assign translationEnable = st_r.transEn;
	assign samePage          = st_r.samePage;
	assign busLockOut        = st_r.lockOut;
	assign cacheFlush        = st_r.cacheFlush;
	assign lateBackoff2      = st_r.lateBo2;
	assign strongOrder       = st_r.strongOrder;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstInt_n);

	property p_err_masked;
		ce && errMasked && !(ctlWrEn && ctlSel == `CCSR_SEL_EPSR) |=> !errTrap;
	endproperty
	a_err_masked: assert property (p_err_masked) else $error("error trap while masked");

	property p_bus_fault;
		ce && busFaultS |=> st_r.busFault;
	endproperty
	a_bus_fault: assert property (p_bus_fault) else $error("bus fault flag not set");

	property p_int_locked;
		ce && lockSeq |=> !st_r.intFlag;
	endproperty
	a_int_locked: assert property (p_int_locked) else $error("interrupt flag up when locked");

	property p_ovf_subu;
		ce && aluValid && aluOp == 2'h3 |=> st_r.overflow == !$past(carry31);
	endproperty
	a_ovf_subu: assert property (p_ovf_subu) else $error("unsigned subtract overflow wrong");

	property p_ovf_user;
		ce && ctlWrEn && !supervisorMode && !aluValid |=> $stable(st_r.overflow);
	endproperty
	a_ovf_user: assert property (p_ovf_user) else $error("user write changed overflow");

	property p_watch;
		watchTrap |-> $past(opValid && ((opRead && readWatchEnable) ||
			(opWrite && writeWatchEnable)));
	endproperty
	a_watch: assert property (p_watch) else $error("watch trap without enabled access");

	sequence s_lock_armed;
		ce && st_r.lockSt == CCSR_LK_ARMED && !trapValid && !unlockInstr;
	endsequence
	sequence s_lock_req;
		busReq && !busReqFetchWb;
	endsequence
	property p_lock_on;
		s_lock_armed and s_lock_req |=> busLockOut ##0 st_r.lockSt == CCSR_LK_HELD;
	endproperty
	a_lock_on: assert property (p_lock_on) else $error("lock output not raised");

	property p_lock_trap;
		ce && trapValid && lockSeq |=> st_r.lockIntr && st_r.lockSt != CCSR_LK_HELD;
	endproperty
	a_lock_trap: assert property (p_lock_trap) else $error("trap did not break lock");

	property p_flush;
		ce && wrSup && ctlSel == `CCSR_SEL_DIRBASE && ctlWrData[`CCSR_DB_ITI]
			|=> cacheFlush ##1 !cacheFlush;
	endproperty
	a_flush: assert property (p_flush) else $error("flush not a single pulse");

	property p_late_sticky;
		lateBackoff2 |=> lateBackoff2;
	endproperty
	a_late_sticky: assert property (p_late_sticky) else $error("late back-off cleared");

	property p_swap_align;
		ce && memValid && st_r.byteSwap && memSize == 2'h2 |=> memAddrOut[1:0] == 2'h0;
	endproperty
	a_swap_align: assert property (p_swap_align) else $error("swapped word not aligned");

endmodule : ccsr_regs

// File: verification/ccsr_bus_partner.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Far-side bus and memory control. It owns the error and interrupt pins and
// the reset straps that the core samples.
module ccsr_bus_partner (
	input  wire logic clk,
	input  wire logic faultReq,
	input  wire logic irqReq,
	input  wire logic strapReq,
	output logic      busFaultPin,
	output logic      irqPin,
	output logic      wrBufEmptyPin_n,
	output logic      lateBackoffStrap
);
	// Error and interrupt pins only move on the bus clock, so the core always sees a full-cycle level.
	always_ff @(posedge clk) begin
		busFaultPin <= faultReq;
		irqPin      <= irqReq;
	end
	// A plain board reports the write buffer empty and fits no one-clock strap, so
	// strong ordering comes up and the two-clock extension stays reachable; the
	// strapped variant shows a busy buffer and the one-clock strap instead.
	assign wrBufEmptyPin_n  = strapReq;
	assign lateBackoffStrap = strapReq;
endmodule : ccsr_bus_partner

// File: verification/test_cpu_control_status_regs.sv
`timescale 1ns/1ps

module test_cpu_control_status_regs;
	import ccsr_pkg::*;
	typedef struct packed {logic [1:0] op; logic c31; logic c30; logic of;} ccsr_ovf_row_t;
	logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, ctlWrEn = 1'b0, ctlRdEn = 1'b0;
	logic [1:0] ctlSel = 2'h0, memSize = 2'h0, aluOp = 2'h0, opSize = 2'h0;
	logic [31:0] ctlWrData = 32'h0, memAddr = 32'h0, opAddr = 32'h0, busAddr = 32'h0;
	logic supervisorMode = 1'b1, parityErr = 1'b0, trapValid = 1'b0, trapDelaySlot = 1'b0;
	logic trapAutoInc = 1'b0, pteCacheDisable = 1'b1, pteWriteThrough = 1'b0, memValid = 1'b0;
	logic aluValid = 1'b0, carry31 = 1'b0, carry30 = 1'b0, fpDecode = 1'b0, fpPipeExec = 1'b0;
	logic opValid = 1'b0, opRead = 1'b0, opWrite = 1'b0, readWatchEnable = 1'b1;
	logic writeWatchEnable = 1'b0, busCycleValid = 1'b0, busReq = 1'b0, busReqFetchWb = 1'b0;
	logic loadStore = 1'b0, lockInstr = 1'b0, unlockInstr = 1'b0, faultReq = 1'b0;
	logic irqReq = 1'b0, busFaultPin, irqPin, wrBufEmptyPin_n, lateBackoffStrap, pteBitOutput;
	logic watchTrap, errTrap, fpTrap, instrTrapSet, translationEnable, samePage, busLockOut;
	logic cacheFlush, lateBackoff2, strongOrder, strapReq = 1'b0;
	logic [31:0] ctlRdData, memAddrOut;
	int fails = 0, total_checks = 0, cyc = 0;
	// Overflow cases: operation, carry out of bit 31, carry out of bit 30, flag.
	ccsr_ovf_row_t rows [8] = '{'{2'h0, 1'b1, 1'b0, 1'b1}, '{2'h0, 1'b1, 1'b1, 1'b0},
		'{2'h1, 1'b1, 1'b1, 1'b1}, '{2'h1, 1'b0, 1'b0, 1'b0}, '{2'h2, 1'b0, 1'b1, 1'b1},
		'{2'h2, 1'b0, 1'b0, 1'b0}, '{2'h3, 1'b0, 1'b0, 1'b1}, '{2'h3, 1'b1, 1'b0, 1'b0}};

	ccsr_bus_partner far (.clk(clk), .faultReq(faultReq), .irqReq(irqReq),
		.strapReq(strapReq),
		.busFaultPin(busFaultPin), .irqPin(irqPin), .wrBufEmptyPin_n(wrBufEmptyPin_n),
		.lateBackoffStrap(lateBackoffStrap));
	ccsr_regs dut (.clk(clk), .rst_n(rst_n), .ce(ce), .ctlWrEn(ctlWrEn), .ctlRdEn(ctlRdEn),
		.ctlSel(ctlSel), .ctlWrData(ctlWrData), .supervisorMode(supervisorMode),
		.busFaultPin(busFaultPin), .irqPin(irqPin), .wrBufEmptyPin_n(wrBufEmptyPin_n),
		.lateBackoffStrap(lateBackoffStrap), .parityErr(parityErr), .trapValid(trapValid),
		.trapDelaySlot(trapDelaySlot), .trapAutoInc(trapAutoInc),
		.pteCacheDisable(pteCacheDisable), .pteWriteThrough(pteWriteThrough),
		.memValid(memValid), .memAddr(memAddr), .memSize(memSize), .aluValid(aluValid),
		.aluOp(aluOp), .carry31(carry31), .carry30(carry30), .fpDecode(fpDecode),
		.fpPipeExec(fpPipeExec), .opValid(opValid), .opRead(opRead), .opWrite(opWrite),
		.opAddr(opAddr), .opSize(opSize), .readWatchEnable(readWatchEnable),
		.writeWatchEnable(writeWatchEnable), .busCycleValid(busCycleValid),
		.busAddr(busAddr), .busReq(busReq), .busReqFetchWb(busReqFetchWb),
		.loadStore(loadStore), .lockInstr(lockInstr), .unlockInstr(unlockInstr),
		.ctlRdData(ctlRdData), .pteBitOutput(pteBitOutput), .memAddrOut(memAddrOut),
		.watchTrap(watchTrap), .errTrap(errTrap), .fpTrap(fpTrap),
		.instrTrapSet(instrTrapSet), .translationEnable(translationEnable),
		.samePage(samePage), .busLockOut(busLockOut), .cacheFlush(cacheFlush),
		.lateBackoff2(lateBackoff2), .strongOrder(strongOrder));

	////////////////////////////////////////////////////////////////////////////////
	// Free-running core clock and a hang guard well beyond the sequence length.
	initial begin
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			fails++;
			final_report();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Inputs move at the falling edge so the design samples settled values.
	task automatic tick(input int k = 1);
		repeat (k) @(negedge clk);
	endtask : tick
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick();
		s = 1'b0;
	endtask : pulse
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [1:0] s, input logic [31:0] d);
		ctlSel = s;
		ctlWrData = d;
		pulse(ctlWrEn);
	endtask : wr
	// Read data is registered, so it is compared one cycle after the strobe; a spare
	// cycle follows so that the next read raises its strobe afresh.
	task automatic rd(input logic [1:0] s, input logic [31:0] m, e, input string n);
		ctlSel = s;
		pulse(ctlRdEn);
		chk(n, e, ctlRdData & m);
		tick();
	endtask : rd
	task automatic watch(input logic [31:0] a, input logic [1:0] sz, input logic w, e);
		opAddr = a;
		opSize = sz;
		opRead = ~w;
		opWrite = w;
		pulse(opValid);
		chk("watchTrap", {31'h0, e}, {31'h0, watchTrap});
		tick();
	endtask : watch
	task automatic final_report();
		if (fails == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : final_report

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence; straps need several cycles after release before reading.
	initial begin
		tick(6);
		rst_n = 1'b1;
		tick(12);
		rd(2'h0, '1, 32'h00010026, "status reset");
		rd(2'h2, '1, 32'h0, "dirbase reset");
		rd(2'h3, '1, 32'h0, "unmapped read");
		chk("strongOrder", 1, strongOrder);
		pulse(parityErr);
		chk("errTrap masked at reset", 0, errTrap);
		wr(2'h0, 32'h0);
		pulse(parityErr);
		chk("errTrap", 1, errTrap);
		tick();
		pulse(parityErr);
		chk("errTrap masked", 0, errTrap);
		rd(2'h0, 32'h80e, 32'h802, "parity flags");
		// User mode: the bus fault must not mark supervisor, and writes bounce.
		wr(2'h0, 32'h0);
		supervisorMode = 1'b0;
		pulse(faultReq);
		tick(5);
		rd(2'h0, 32'h80e, 32'h004, "bus flags");
		wr(2'h0, 32'h400);
		rd(2'h0, 32'h400, 32'h0, "user write");
		supervisorMode = 1'b1;
		wr(2'h0, 32'h0);
		supervisorMode = 1'b0;
		foreach (rows[i]) begin
			aluOp = rows[i].op;
			carry31 = rows[i].c31;
			carry30 = rows[i].c30;
			pulse(aluValid);
			rd(2'h0, 32'h400, {21'h0, rows[i].of, 10'h0}, "overflow");
		end
		supervisorMode = 1'b1;
		// Watch compare at the size boundaries of sizes 0 to 2 and per direction.
		wr(2'h1, 32'h1003);
		watch(32'h1002, 2'h1, 1'b0, 1'b1);
		watch(32'h1000, 2'h1, 1'b0, 1'b0);
		watch(32'h1000, 2'h2, 1'b0, 1'b1);
		watch(32'h1003, 2'h0, 1'b1, 1'b0);
		writeWatchEnable = 1'b1;
		watch(32'h1003, 2'h0, 1'b1, 1'b1);
		wr(2'h0, 32'h200);
		for (int s = 0; s < 4; s++) begin
			memAddr = 32'h100;
			memSize = s[1:0];
			pulse(memValid);
			chk("memAddrOut", 32'h107 & ~((32'h1 << s) - 32'h1), memAddrOut);
			tick();
		end
		chk("pte cache disable", 1, pteBitOutput);
		wr(2'h0, 32'h100);
		tick(2);
		chk("pte write through", 0, pteBitOutput);
		wr(2'h0, 32'h4000);
		pulse(fpDecode);
		chk("fpTrap", 1, fpTrap);
		chk("instrTrapSet", 1, instrTrapSet);
		rd(2'h0, 32'hc000, 32'hc000, "pipe trap flags");
		wr(2'h0, 32'h0);
		pulse(fpPipeExec);
		rd(2'h0, 32'h8000, 32'h8000, "pipe used");
		trapDelaySlot = 1'b1;
		trapAutoInc = 1'b1;
		pulse(trapValid);
		trapDelaySlot = 1'b0;
		trapAutoInc = 1'b0;
		rd(2'h0, 32'h3001, 32'h3000, "trap flags");
		// Locked sequence: fetches do not lock, and the output drops late.
		irqReq = 1'b1;
		tick(5);
		rd(2'h0, 32'h8, 32'h8, "irq flag");
		pulse(lockInstr);
		busReqFetchWb = 1'b1;
		pulse(busReq);
		busReqFetchWb = 1'b0;
		tick();
		chk("lock on fetch", 0, busLockOut);
		pulse(busReq);
		tick();
		chk("lock", 1, busLockOut);
		rd(2'h0, 32'h8, 32'h0, "irq in lock");
		pulse(unlockInstr);
		tick();
		chk("lock held", 1, busLockOut);
		pulse(loadStore);
		tick();
		chk("lock drop", 0, busLockOut);
		pulse(lockInstr);
		pulse(busReq);
		pulse(trapValid);
		rd(2'h2, 32'h10, 32'h0, "lock bit");
		rd(2'h0, 32'h1, 32'h1, "lock interrupted");
		pulse(loadStore);
		tick();
		chk("lock drop on trap", 0, busLockOut);
		// Directory base: flush pulse, sticky extension, page compare above the low 13 bits.
		wr(2'h2, 32'habcde063);
		chk("cacheFlush", 1, cacheFlush);
		rd(2'h2, '1, 32'habcde043, "dirbase");
		chk("translation", 1, translationEnable);
		chk("late backoff", 1, lateBackoff2);
		busCycleValid = 1'b1;
		busAddr = 32'h20000000;
		tick();
		busAddr = 32'h20001fff;
		tick();
		chk("same page", 1, samePage);
		busAddr = 32'h20002000;
		tick();
		busCycleValid = 1'b0;
		chk("new page", 0, samePage);
		wr(2'h2, 32'h0);
		rd(2'h2, 32'h41, 32'h40, "sticky backoff");
		chk("translation off", 0, translationEnable);
		// A write while the clock enable is low must not land.
		ce = 1'b0;
		wr(2'h2, 32'h1);
		ce = 1'b1;
		chk("frozen write", 0, translationEnable);
		// Mid-run reset with the strapped board: weak ordering, no two-clock extension.
		strapReq = 1'b1;
		rst_n = 1'b0;
		tick(2);
		rst_n = 1'b1;
		tick(12);
		rd(2'h2, '1, 32'h0, "dirbase after reset");
		rd(2'h0, '1, 32'h0000002e, "status after reset");
		wr(2'h2, 32'h40);
		rd(2'h2, 32'h40, 32'h0, "strap blocks backoff");
		final_report();
	end
endmodule : test_cpu_control_status_regs
